//--- design/apm_consts.svh
// Constants of the audio port configuration and input mixer block
`ifndef APM_CONSTS_SVH
`define APM_CONSTS_SVH

// Register indices; byte address is four times the index
`define APM_IDX_CFG2    10'h009
`define APM_IDX_MIX     10'h00a
`define APM_IDX_SLOT1   10'h00b
`define APM_IDX_IRQST   10'h010
`define APM_IDX_IRQMSK  10'h011

// Reset values
`define APM_RST_CFG2    8'h00
`define APM_RST_MIX     8'h00
`define APM_RST_SLOT1   8'h00
`define APM_RST_IRQ     3'h0

// Mixing select codes
`define APM_MIX_OFF     2'h0
`define APM_MIX_SLOT0   2'h1
`define APM_MIX_SLOT1   2'h2
`define APM_MIX_SPLIT   2'h3

// Output word length codes
`define APM_WLEN_16     2'h0
`define APM_WLEN_20     2'h1
`define APM_WLEN_24     2'h2
`define APM_WLEN_32     2'h3

// Full-scale positive values per word length, 34-bit sum domain
`define APM_MAX_16      34'h0_0000_7fff
`define APM_MAX_20      34'h0_0007_ffff
`define APM_MAX_24      34'h0_007f_ffff
`define APM_MAX_32      34'h0_7fff_ffff

// Interrupt status bit positions
`define APM_IRQ_FAULT   0
`define APM_IRQ_RESUME  1
`define APM_IRQ_SAT     2

// Slot field: top bit marks the right-hand half in two-channel formats
`define APM_SLOT_RIGHT  5

`endif

//--- design/apm_pkg.sv
// Types of the audio port configuration and input mixer block
`default_nettype none
package apm_pkg;

    // Port configuration register two
    typedef struct packed {
        logic       daisy;          // 1: chained topology, 0: shared bus
        logic       rsvdSix;        // Reads zero
        logic       errDetectOff;   // 1: bus errors ignored
        logic       faultResumeOff; // 1: stay down after an error
        logic [3:0] rsvdLow;        // Reads zero
    } apm_cfg2_s;

    // Input mixing configuration register
    typedef struct packed {
        logic [1:0] mixSel;         // Mixing source select
        logic [1:0] gainSel;        // Attenuation in 6 dB steps
        logic       inputMixNegate; // Negate received samples
        logic [2:0] rsvdLow;        // Reads zero
    } apm_mix_s;

    // Channel one slot select register
    typedef struct packed {
        logic [1:0] rsvdHigh;                // Reads zero
        logic [5:0] firstChannelSlotField;   // Output slot 0..63
    } apm_slot_s;

    // A pair of channel samples, first and second
    typedef struct packed {
        logic [31:0] first;
        logic [31:0] second;
    } apm_pair_s;

    // Bus error handling state
    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_FAULT = 2'b01,
        ST_HALT  = 2'b10
    } apm_state_e;

    // Whole state of the top module
    typedef struct packed {
        apm_cfg2_s   cfg2;
        apm_mix_s    mix;
        apm_slot_s   slot;
        logic [2:0]  irqStatus;
        logic [2:0]  irqMask;
        apm_state_e  state;
        apm_pair_s   heldInput;
        apm_pair_s   mixOut;
        logic        mixValid;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        irq;
    } apm_regs_s;

endpackage : apm_pkg
`default_nettype wire

//--- design/apm_mix_lane.sv
// One mixing lane: scale, optionally negate, add and saturate
`include "apm_consts.svh"
`default_nettype none
module apm_mix_lane (
    input  wire logic        [31:0] chanSample,
    input  wire logic        [31:0] mixSample,
    input  wire logic               mixOn,
    input  wire logic        [1:0]  gainSel,
    input  wire logic               inputMixNegate,
    input  wire logic        [1:0]  wordLen,
    output logic             [31:0] result,
    output logic                    saturated
);

    logic signed [31:0] scaled;   // Attenuated input sample
    logic signed [33:0] addend;   // Signed term added to channel data
    logic signed [33:0] sum;      // Unclamped sum
    logic signed [33:0] maxVal;   // Positive full scale
    logic signed [33:0] minVal;   // Negative full scale

    // Each arithmetic shift is close to 6 dB of attenuation
    always_comb begin
        scaled = $signed(mixSample) >>> gainSel;
        if (inputMixNegate) begin
            addend = -{{2{scaled[31]}}, scaled};
        end else begin
            addend = {{2{scaled[31]}}, scaled};
        end
        if (!mixOn) begin
            addend = '0;
        end
        sum = $signed({{2{chanSample[31]}}, chanSample}) + addend;
    end

    // Limits follow the configured output word length
    always_comb begin
        case (wordLen)
            `APM_WLEN_16: maxVal = `APM_MAX_16;
            `APM_WLEN_20: maxVal = `APM_MAX_20;
            `APM_WLEN_24: maxVal = `APM_MAX_24;
            `APM_WLEN_32: maxVal = `APM_MAX_32;
            default:      maxVal = `APM_MAX_32;
        endcase
        minVal = ~maxVal;
    end

    always_comb begin
        if (sum > maxVal) begin
            result    = maxVal[31:0];
            saturated = 1'b1;
        end else if (sum < minVal) begin
            result    = minVal[31:0];
            saturated = 1'b1;
        end else begin
            result    = sum[31:0];
            saturated = 1'b0;
        end
    end

endmodule : apm_mix_lane
`default_nettype wire

//--- design/apm_port_mixer.sv
// Audio port configuration, bus error handling and input mixer with APB registers
`include "apm_consts.svh"
`default_nettype none
module apm_port_mixer (
    input  wire logic                    clk,
    input  wire logic                    rst,
    // APB slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic            [11:0]  paddr,
    input  wire logic            [31:0]  pwdata,
    input  wire logic            [3:0]   pstrb,
    output logic                 [31:0]  prdata,
    output logic                         pready,
    output logic                         pslverr,
    output logic                         irq,
    // Port status and format
    input  wire logic                    busError,
    input  wire logic            [1:0]   wordLen,
    // Samples from the general input pin deserialiser
    input  wire logic                    inputValid,
    input  wire apm_pkg::apm_pair_s      receivedInput,
    // Channel output samples before mixing
    input  wire logic                    chanValid,
    input  wire apm_pkg::apm_pair_s      chanIn,
    // Mixed samples and port controls
    output apm_pkg::apm_pair_s           mixOut,
    output logic                         mixValid,
    output logic                         devicePowerDown,
    output logic                         daisyChain,
    output logic                 [5:0]   firstChannelSlot,
    output logic                         firstSlotRight
);

    ////////////////////////////////////////////////////////////////////////////
    // State and decode

    apm_pkg::apm_regs_s state_reg;     // All flip-flops of the block
    apm_pkg::apm_regs_s state_next;    // Their next value

    logic        addrAligned;          // Low address bits are zero
    logic [9:0]  regIndex;             // Word index of the access
    logic        accessPhase;          // Access phase, answer not yet given
    logic        takeEdge;             // Edge where the transfer completes
    logic        wrTake;               // Write taking effect now
    logic        lane0Written;         // Byte lane zero is strobed
    logic        hitCfg2;              // Index decodes
    logic        hitMix;
    logic        hitSlot;
    logic        hitIrqSt;
    logic        hitIrqMsk;
    logic        hitAny;               // Any mapped register
    logic        cfgWrite;             // Host configuration write
    logic [31:0] readValue;            // Read mux result
    logic        errSeen;              // Error that the block honours
    logic [2:0]  irqEvents;            // Events this cycle
    logic [2:0]  irqClear;             // Write-one-to-clear mask
    logic        mixFirstOn;           // Lane enables
    logic        mixSecondOn;
    logic [31:0] srcFirst;             // Mix source per lane
    logic [31:0] srcSecond;
    apm_pkg::apm_pair_s laneResult;    // Lane outputs
    logic        satFirst;
    logic        satSecond;
    logic        running;              // Not powered down

    ////////////////////////////////////////////////////////////////////////////
    // APB address decode

    // Byte address is four times the register index
    always_comb begin
        addrAligned  = (paddr[1:0] == 2'h0);
        regIndex     = paddr[11:2];
        hitCfg2      = addrAligned && (regIndex == `APM_IDX_CFG2);
        hitMix       = addrAligned && (regIndex == `APM_IDX_MIX);
        hitSlot      = addrAligned && (regIndex == `APM_IDX_SLOT1);
        hitIrqSt     = addrAligned && (regIndex == `APM_IDX_IRQST);
        hitIrqMsk    = addrAligned && (regIndex == `APM_IDX_IRQMSK);
        hitAny       = hitCfg2 || hitMix || hitSlot || hitIrqSt || hitIrqMsk;
        // One wait state: pready rises on the second access cycle
        accessPhase  = psel && penable && !state_reg.pready;
        takeEdge     = psel && penable && state_reg.pready;
        // Only lane zero carries register bits; other lanes are ignored
        lane0Written = pstrb[0];
        wrTake       = takeEdge && pwrite && hitAny && lane0Written;
        cfgWrite     = wrTake && (hitCfg2 || hitMix || hitSlot);
    end

    // Read mux; reserved fields are held at zero so read zero
    always_comb begin
        readValue = 32'h0;
        if (hitCfg2) begin
            readValue[7:0] = state_reg.cfg2;
        end else if (hitMix) begin
            readValue[7:0] = state_reg.mix;
        end else if (hitSlot) begin
            readValue[7:0] = state_reg.slot;
        end else if (hitIrqSt) begin
            readValue[2:0] = state_reg.irqStatus;
        end else if (hitIrqMsk) begin
            readValue[2:0] = state_reg.irqMask;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mixing lanes

    // Source routing per mixing select
    always_comb begin
        case (state_reg.mix.mixSel)
            `APM_MIX_OFF: begin
                mixFirstOn  = 1'b0;
                mixSecondOn = 1'b0;
                srcFirst    = state_reg.heldInput.first;
                srcSecond   = state_reg.heldInput.second;
            end
            `APM_MIX_SLOT0: begin
                mixFirstOn  = 1'b1;
                mixSecondOn = 1'b1;
                srcFirst    = state_reg.heldInput.first;
                srcSecond   = state_reg.heldInput.first;
            end
            `APM_MIX_SLOT1: begin
                mixFirstOn  = 1'b1;
                mixSecondOn = 1'b1;
                srcFirst    = state_reg.heldInput.second;
                srcSecond   = state_reg.heldInput.second;
            end
            `APM_MIX_SPLIT: begin
                mixFirstOn  = 1'b1;
                mixSecondOn = 1'b1;
                srcFirst    = state_reg.heldInput.first;
                srcSecond   = state_reg.heldInput.second;
            end
            default: begin
                mixFirstOn  = 1'b0;
                mixSecondOn = 1'b0;
                srcFirst    = state_reg.heldInput.first;
                srcSecond   = state_reg.heldInput.second;
            end
        endcase
    end

    // Channel one lane
    apm_mix_lane uLaneFirst (
        .chanSample     (chanIn.first),
        .mixSample      (srcFirst),
        .mixOn          (mixFirstOn),
        .gainSel        (state_reg.mix.gainSel),
        .inputMixNegate (state_reg.mix.inputMixNegate),
        .wordLen        (wordLen),
        .result         (laneResult.first),
        .saturated      (satFirst)
    );

    // Channel two lane
    apm_mix_lane uLaneSecond (
        .chanSample     (chanIn.second),
        .mixSample      (srcSecond),
        .mixOn          (mixSecondOn),
        .gainSel        (state_reg.mix.gainSel),
        .inputMixNegate (state_reg.mix.inputMixNegate),
        .wordLen        (wordLen),
        .result         (laneResult.second),
        .saturated      (satSecond)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        state_next = state_reg;
        irqEvents  = 3'h0;
        irqClear   = 3'h0;
        running    = (state_reg.state == apm_pkg::ST_RUN);
        // detection active only while the bit is zero
        errSeen    = busError && !state_reg.cfg2.errDetectOff;

        // APB answer, one wait state, registered
        state_next.pready = accessPhase;
        if (accessPhase) begin
            state_next.pslverr = !hitAny;
            state_next.prdata  = pwrite ? 32'h0 : readValue;
        end else begin
            state_next.pslverr = 1'b0;
            state_next.prdata  = 32'h0;
        end

        // Register writes at the completing edge
        if (wrTake && hitCfg2) begin
            state_next.cfg2 = pwdata[7:0];
            state_next.cfg2.rsvdSix = 1'b0;
            state_next.cfg2.rsvdLow = 4'h0;
        end
        if (wrTake && hitMix) begin
            state_next.mix = pwdata[7:0];
            state_next.mix.rsvdLow = 3'h0;
        end
        if (wrTake && hitSlot) begin
            state_next.slot = pwdata[7:0];
            state_next.slot.rsvdHigh = 2'h0;
        end
        if (wrTake && hitIrqMsk) begin
            state_next.irqMask = pwdata[2:0];
        end
        if (wrTake && hitIrqSt) begin
            irqClear = pwdata[2:0];
        end

        // Bus error handling
        case (state_reg.state)
            apm_pkg::ST_RUN: begin
                if (errSeen) begin
                    state_next.state = apm_pkg::ST_FAULT;
                    irqEvents[`APM_IRQ_FAULT] = 1'b1;
                end
            end
            apm_pkg::ST_FAULT: begin
                if (!errSeen) begin
                    if (state_reg.cfg2.faultResumeOff) begin
                        state_next.state = apm_pkg::ST_HALT;
                    end else begin
                        state_next.state = apm_pkg::ST_RUN;
                        irqEvents[`APM_IRQ_RESUME] = 1'b1;
                    end
                end
            end
            apm_pkg::ST_HALT: begin
                if (cfgWrite) begin
                    if (errSeen) begin
                        state_next.state = apm_pkg::ST_FAULT;
                    end else begin
                        state_next.state = apm_pkg::ST_RUN;
                        irqEvents[`APM_IRQ_RESUME] = 1'b1;
                    end
                end
            end
            default: begin
                state_next.state = apm_pkg::ST_HALT;
            end
        endcase

        // Received samples are held until the next pair arrives
        if (inputValid) begin
            state_next.heldInput = receivedInput;
        end

        // Mixed output, only while powered up
        state_next.mixValid = chanValid && running;
        if (chanValid && running) begin
            state_next.mixOut = laneResult;
            if (satFirst || satSecond) begin
                irqEvents[`APM_IRQ_SAT] = 1'b1;
            end
        end

        // Sticky status: a new event wins over a clear in the same cycle
        state_next.irqStatus = (state_reg.irqStatus & ~irqClear) | irqEvents;
        state_next.irq       = |(state_next.irqStatus & state_next.irqMask);
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    // Synchronous reset to documented values
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg           <= '0;
            state_reg.cfg2      <= `APM_RST_CFG2;
            state_reg.mix       <= `APM_RST_MIX;
            state_reg.slot      <= `APM_RST_SLOT1;
            state_reg.irqStatus <= `APM_RST_IRQ;
            state_reg.irqMask   <= `APM_RST_IRQ;
            state_reg.state     <= apm_pkg::ST_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from the state register

    assign prdata           = state_reg.prdata;
    assign pready           = state_reg.pready;
    assign pslverr          = state_reg.pslverr;
    assign irq              = state_reg.irq;
    assign mixOut           = state_reg.mixOut;
    assign mixValid         = state_reg.mixValid;
    assign devicePowerDown  = (state_reg.state != apm_pkg::ST_RUN);
    // chained use relies on mixing being off
    assign daisyChain       = state_reg.cfg2.daisy;
    assign firstChannelSlot = state_reg.slot.firstChannelSlotField;
    assign firstSlotRight   = state_reg.slot.firstChannelSlotField[`APM_SLOT_RIGHT];

endmodule : apm_port_mixer
`default_nettype wire

//--- bench/apm_port_mixer_props.sv
// Checker of the port mixer: bus timing, config effects and fault handling
`default_nettype none
module apm_port_mixer_props (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        busError,
    input wire logic        chanValid,
    input wire logic        mixValid,
    input wire logic        devicePowerDown,
    input wire logic        daisyChain,
    input wire logic [5:0]  firstChannelSlot,
    input wire logic        firstSlotRight
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic wrCfg;   // Completed write to the port config register
    logic errOff;  // Shadow of the error-ignore bit
    logic resOff;  // Shadow of the resume-off bit
    assign wrCfg = psel && penable && pready && pwrite && pstrb[0] && paddr == 12'h024;
    logic wrSlot;  // Completed write to the slot select register
    assign wrSlot = psel && penable && pready && pwrite && pstrb[0] && paddr == 12'h02c;

    // Shadows follow the register so the fault rules can be judged from the pins
    always_ff @(posedge clk) begin
        if (rst) begin
            errOff <= 1'b0;
            resOff <= 1'b0;
        end else if (wrCfg) begin
            errOff <= pwdata[5];
            resOff <= pwdata[4];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Exactly one wait state, answer lasts one cycle
    property p_rdy; psel && penable && !pready |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("pready late");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("pready too long");
    property p_idle; !pready |-> prdata == 32'h0 && !pslverr; endproperty
    a_idle: assert property (p_idle) else $error("read bus not quiet");
    property p_rsv; pready && !pwrite && !pslverr |-> prdata[31:8] == 24'h0 &&
        (paddr != 12'h024 || (prdata[6:0] & 7'h4f) == 7'h0); endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits nonzero");
    ////////////////////////////////////////////////////////////////////////////
    // topology follows write
    property p_daisy; wrCfg |=> daisyChain == $past(pwdata[7]); endproperty
    a_daisy: assert property (p_daisy) else $error("topology not updated");
    property p_mixv; mixValid |-> $past(chanValid) && !$past(devicePowerDown); endproperty
    a_mixv: assert property (p_mixv) else $error("stray mixed sample");
    property p_slot; firstSlotRight == firstChannelSlot[5]; endproperty
    a_slot: assert property (p_slot) else $error("slot half wrong");
    property p_slotw; wrSlot |=> firstChannelSlot == $past(pwdata[5:0]); endproperty
    a_slotw: assert property (p_slotw) else $error("slot not updated");
    property p_pd; busError && !errOff && !devicePowerDown |=> devicePowerDown; endproperty
    a_pd: assert property (p_pd) else $error("error not detected");
    property p_resume; devicePowerDown && !busError && !resOff |=> !devicePowerDown; endproperty
    a_resume: assert property (p_resume) else $error("no auto resume");
endmodule : apm_port_mixer_props

bind apm_port_mixer apm_port_mixer_props i_apm_port_mixer_props (.clk, .rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .busError, .chanValid,
    .mixValid, .devicePowerDown, .daisyChain, .firstChannelSlot, .firstSlotRight);
`default_nettype wire

//--- bench/apm_src_model.sv
// Model of the sample source behind the general input pin
`default_nettype none
module apm_src_model (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               go,
    input  wire apm_pkg::apm_pair_s data,
    output var  logic               inputValid,
    output apm_pkg::apm_pair_s      receivedInput
);
    timeunit 1ns;
    timeprecision 1ns;

    // both slot words
    // Between strobes the words toggle, so a stale capture cannot pass
    always_ff @(posedge clk) begin
        if (rst) begin
            inputValid    <= 1'b0;
            receivedInput <= '0;
        end else begin
            inputValid    <= go;
            receivedInput <= go ? data : ~receivedInput;
        end
    end
endmodule : apm_src_model
`default_nettype wire

//--- bench/test_apm_port_mixer.sv
// Testbench of the audio port configuration and input mixer
`default_nettype none
module test_apm_port_mixer;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] S1 = 32'h0000_0400;  // First input word
    localparam logic [31:0] S2 = 32'hffff_fc00;  // Second input word, negative
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic busError = 1'b0, chanValid = 1'b0, go = 1'b0, inputValid, pready, pslverr, irq;
    logic mixValid, pd, daisy, right;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd, cv;
    logic [1:0]  wordLen = 2'h3;
    logic [5:0]  slot;
    logic [7:0]  mv;
    logic        er;
    apm_pkg::apm_pair_s rx, mixOut, chanIn = '0, srcData = '0;
    int failures = 0, samples_checked = 0, cyc = 0;
    logic [9:0] ix [5] = '{10'h009, 10'h009, 10'h00a, 10'h00b, 10'h00b};
    logic [7:0] wd [5] = '{8'hff, 8'h00, 8'hff, 8'hff, 8'h1f};
    logic [7:0] ex [5] = '{8'hb0, 8'h00, 8'hf8, 8'h3f, 8'h1f};

    apm_port_mixer i_apm_port_mixer (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb(4'hf), .prdata, .pready, .pslverr, .irq, .busError, .wordLen, .inputValid,
        .receivedInput(rx), .chanValid, .chanIn, .mixOut, .mixValid, .devicePowerDown(pd),
        .daisyChain(daisy), .firstChannelSlot(slot), .firstSlotRight(right));
    apm_src_model i_apm_src_model (.clk, .rst, .go, .data(srcData), .inputValid, .receivedInput(rx));

    // Clock of 100 ns
    initial begin
        forever #50 clk = ~clk;
    end

    // Hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            stop_test();
        end
    end

    task automatic stop_test;
        $display("Comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    task automatic check(input string nm, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // One APB transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle

    // One channel pair in; returns at the edge where the result is sampled
    task automatic send(input logic [31:0] a, b);
        @(posedge clk);
        chanIn    <= {a, b};
        chanValid <= 1'b1;
        @(posedge clk);
        chanValid <= 1'b0;
        @(posedge clk);
    endtask : send

    // Expected lane: shift, negate, add, clamp to the output word length
    function automatic logic [31:0] mx(input logic [31:0] c, s, input logic [1:0] g,
                                       input logic n, on, input logic [1:0] w);
        logic signed [33:0] a, v, m;
        a = $signed(s);
        v = a >>> g;
        v = on ? (n ? -v : v) : 34'sh0;
        v = $signed(c) + v;
        m = (34'sh1 <<< (w == 2'h3 ? 31 : 15 + 4 * w)) - 34'sh1;
        if (v > m) v = m;
        if (v < -m - 34'sh1) v = -m - 34'sh1;
        return v[31:0];
    endfunction : mx

    initial begin
        idle(4);
        rst <= 1'b0;
        for (int i = 9; i < 12; i++) begin
            apb(1'b0, 10'(i), 8'h0);
            check("reset value", rd, 32'h0);
        end
        // chained only while mixing off; reserved written as ones on purpose
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, ix[i], wd[i]);
            apb(1'b0, ix[i], 8'h0);
            check("register", rd, {24'h0, ex[i]});
            if (ix[i] == 10'h009) check("daisy", 32'(daisy), 32'(ex[i][7]));
            if (ix[i] == 10'h00b) check("right", 32'(right), 32'(ex[i][5]));
        end
        apb(1'b0, 10'h020, 8'h0);
        check("unmapped", {rd[31:1], er}, 32'h1);
        @(posedge clk);
        srcData <= {S1, S2};
        go      <= 1'b1;
        @(posedge clk);
        go      <= 1'b0;
        // Every select, gain and inversion code
        for (int k = 0; k < 32; k++) begin
            mv = {k[4:0], 3'h0};
            apb(1'b1, 10'h00a, mv);
            send(32'h1000, 32'h2000);
            check("mixValid", 32'(mixValid), 32'h1);
            check("first", mixOut.first, mx(32'h1000, mv[7:6] == 2'h2 ? S2 : S1, mv[5:4], mv[3],
                  mv[7:6] != 2'h0, 2'h3));
            check("second", mixOut.second, mx(32'h2000, mv[7:6] == 2'h1 ? S1 : S2, mv[5:4], mv[3],
                  mv[7:6] != 2'h0, 2'h3));
        end
        // Each shorter word length, sum pushed past both full scales
        for (int n = 0; n < 6; n++) begin
            wordLen <= 2'(n / 2);
            apb(1'b1, 10'h00a, 8'h40 | 8'(n % 2 << 3));
            cv = (32'h8000 << 4 * (n / 2)) - 32'h100;
            send(cv, -cv);
            check("sat first", mixOut.first, mx(cv, S1, 2'h0, n[0], 1'b1, 2'(n / 2)));
            check("sat second", mixOut.second, mx(-cv, S1, 2'h0, n[0], 1'b1, 2'(n / 2)));
        end
        apb(1'b0, 10'h010, 8'h0);
        check("sat status", rd, 32'h4);
        check("irq masked", 32'(irq), 32'h0);
        apb(1'b1, 10'h011, 8'h04);
        idle(2);
        check("irq on", 32'(irq), 32'h1);
        apb(1'b1, 10'h010, 8'h04);
        idle(2);
        check("irq cleared", 32'(irq), 32'h0);
        apb(1'b1, 10'h011, 8'h01);
        busError <= 1'b1;
        idle(3);
        check("fault down", 32'(pd), 32'h1);
        check("fault irq", 32'(irq), 32'h1);
        send(32'h1, 32'h2);
        check("no sample", 32'(mixValid), 32'h0);
        busError <= 1'b0;
        idle(3);
        check("resumed", 32'(pd), 32'h0);
        apb(1'b0, 10'h010, 8'h0);
        check("fault status", rd, 32'h3);
        apb(1'b1, 10'h010, 8'h07);
        apb(1'b1, 10'h009, 8'h20);
        busError <= 1'b1;
        idle(3);
        check("ignored", 32'(pd), 32'h0);
        busError <= 1'b0;
        apb(1'b1, 10'h009, 8'h10);
        busError <= 1'b1;
        idle(3);
        busError <= 1'b0;
        idle(3);
        check("halted", 32'(pd), 32'h1);
        apb(1'b1, 10'h00b, 8'h3f);
        idle(3);
        check("released", 32'(pd), 32'h0);
        check("slot", {25'h0, right, slot}, 32'h7f);
        stop_test();
    end
endmodule : test_apm_port_mixer
`default_nettype wire
